// file: common/adcsr_regs.vh
// register map of the amplifier control and status group
// assumes an 8-bit register pointer and 16-bit register words
`ifndef ADCSR_REGS_VH
`define ADCSR_REGS_VH

`define ADCSR_HP_FILTER_CTRL_OFS    8'h12
`define ADCSR_GAIN_CTRL_OFS         8'h13
`define ADCSR_MUTE_LIMITER_CTRL_OFS 8'h14
`define ADCSR_MISC_STATUS_OFS       8'h15

`define ADCSR_HP_CORNER_RST   9'h004
`define ADCSR_GAIN_RST        8'hbd
`define ADCSR_ZERO_CROSS_RST  1'b1
`define ADCSR_GAIN_RSVD_RST   4'h0
`define ADCSR_DEEMPH_RST      2'h0
`define ADCSR_HARD_MUTE_RST   1'b0
`define ADCSR_SOFT_MUTE_RST   1'b0
`define ADCSR_PLIM_RST        8'hbd

`define ADCSR_ZERO_CROSS_BIT  12
`define ADCSR_DEEMPH_MSB      11
`define ADCSR_DEEMPH_LSB      10
`define ADCSR_HARD_MUTE_BIT   9
`define ADCSR_SOFT_MUTE_BIT   8

`define ADCSR_ST_SWITCHING_BIT 14
`define ADCSR_ST_REG_GOOD_BIT  13
`define ADCSR_ST_AMP_MSB       10
`define ADCSR_ST_AMP_LSB       9
`define ADCSR_ST_IN2_RATIO_BIT 8
`define ADCSR_ST_IN2_HIGH_BIT  7
`define ADCSR_ST_IN2_LOW_BIT   6
`define ADCSR_ST_IN1_RATIO_BIT 5
`define ADCSR_ST_IN1_HIGH_BIT  4
`define ADCSR_ST_IN1_LOW_BIT   3
`define ADCSR_ST_OCP_A_BIT     2
`define ADCSR_ST_OCP_B_BIT     1

`define ADCSR_I2C_BASE_ADDR   5'h1a

`endif

// file: hw/adcsr_sync.v
// two-stage synchroniser for pin-level inputs
// assumes the inputs are asynchronous to clk
module adcsr_sync #(
	parameter WIDTH = 1
) (
	input  wire             clk,
	input  wire             reset_n,
	input  wire [WIDTH-1:0] async_in,
	output reg  [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_reg;

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_reg <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule // adcsr_sync

// file: hw/adcsr_clkmon.v
// frame clock and bit clock monitor for one serial audio input
// assumes synchronised clocks and limits set by the selected format
module adcsr_clkmon (
	input  wire        clk,
	input  wire        reset_n,
	input  wire        bit_clock_s,
	input  wire        frame_clock_s,
	input  wire [15:0] period_min,
	input  wire [15:0] period_max,
	input  wire [7:0]  ratio_expect,
	output reg         ratio_error,
	output reg         rate_high,
	output reg         rate_low
);
	reg        bclk_d_reg;
	reg        fclk_d_reg;
	reg        started_reg;
	reg [15:0] period_reg;
	reg [7:0]  bits_reg;
	wire       fclk_rise = frame_clock_s & ~fclk_d_reg;
	wire       bclk_rise = bit_clock_s & ~bclk_d_reg;

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bclk_d_reg  <= 1'b0;
			fclk_d_reg  <= 1'b0;
			started_reg <= 1'b0;
			period_reg  <= 16'h0000;
			bits_reg    <= 8'h00;
			ratio_error <= 1'b0;
			rate_high   <= 1'b0;
			rate_low    <= 1'b0;
		end else begin
			bclk_d_reg <= bit_clock_s;
			fclk_d_reg <= frame_clock_s;
			if (fclk_rise) begin
				started_reg <= 1'b1;
				period_reg  <= 16'h0001;
				bits_reg    <= {7'h00, bclk_rise};
				// flags follow the last frame, nothing latches
				if (started_reg) begin
					rate_high   <= (period_reg < period_min);
					rate_low    <= (period_reg > period_max);
					ratio_error <= (bits_reg != ratio_expect);
				end
			end else begin
				if (period_reg != 16'hffff)
					period_reg <= period_reg + 16'h0001;
				if (bclk_rise && bits_reg != 8'hff)
					bits_reg <= bits_reg + 8'h01;
				// frame clock stalled: too slow
				if (period_reg > period_max)
					rate_low <= 1'b1;
			end
		end
	end
endmodule // adcsr_clkmon

// file: hw/adcsr_top.v
// control and status register group of the amplifier, reached over I2C
// assumes open-drain pad logic outside, DSP and power stage on clk
`include "adcsr_regs.vh"
module adcsr_top #(
	parameter MUTE_PWM_HALF = 16'd250,
	parameter RAMP_STEP     = 16'd1000
) (
	input  wire        clk,
	input  wire        reset_n,
	input  wire        scl_in,
	input  wire        sda_in,
	output wire        sda_out,
	output reg         sda_oe,
	input  wire [1:0]  i2c_addr_sel,
	input  wire        serial1_bit_clock,
	input  wire        serial1_frame_clock,
	input  wire        serial2_bit_clock,
	input  wire        serial2_frame_clock,
	input  wire [15:0] input1_period_min,
	input  wire [15:0] input1_period_max,
	input  wire [7:0]  input1_ratio_expect,
	input  wire [15:0] input2_period_min,
	input  wire [15:0] input2_period_max,
	input  wire [7:0]  input2_ratio_expect,
	input  wire        audio_zero_cross,
	input  wire        power_stage_switching,
	input  wire        analog_regulator_on,
	input  wire        analog_regulator_level_ok,
	input  wire [1:0]  output_stage_mode_state,
	input  wire        overcurrent_active_pin_a,
	input  wire        overcurrent_active_pin_b,
	output reg  [8:0]  highpass_corner_setting,
	output reg  [7:0]  gain_setting,
	output reg  [7:0]  gain_applied,
	output reg  [1:0]  deemph_select,
	output reg  [7:0]  power_limit_setting,
	output reg         hard_mute_active,
	output reg         mute_pwm,
	output reg  [7:0]  soft_mute_gain
);
	localparam ST_IDLE = 5'b00001;
	localparam ST_RX   = 5'b00010;
	localparam ST_ACK  = 5'b00100;
	localparam ST_TX   = 5'b01000;
	localparam ST_RACK = 5'b10000;

	reg        zero_cross_update_enable;
	reg  [3:0] gain_rsvd_reg;
	reg        soft_mute_enable;
	wire [1:0] pins_n_s;
	wire [1:0] addr_s;
	wire [3:0] serial_s;
	reg        scl_d_reg;
	reg        sda_d_reg;
	reg  [4:0] state_reg;
	reg  [3:0] bit_cnt_reg;
	reg  [7:0] shift_reg;
	reg  [1:0] byte_idx_reg;
	reg        rw_reg;
	reg        half_reg;
	reg  [7:0] ptr_reg;
	reg  [7:0] msb_hold_reg;
	reg        mack_reg;
	reg [15:0] pwm_cnt_reg;
	reg [15:0] ramp_cnt_reg;
	reg  [4:0] ramp_pos_reg;
	reg [15:0] rd_word;
	reg [15:0] status_word;
	wire       scl_s = ~pins_n_s[0];
	wire       sda_s = ~pins_n_s[1];
	wire       scl_rise = scl_s & ~scl_d_reg;
	wire       scl_fall = ~scl_s & scl_d_reg;
	wire       start_cond = scl_s & scl_d_reg & ~sda_s & sda_d_reg;
	wire       stop_cond = scl_s & scl_d_reg & sda_s & ~sda_d_reg;
	wire       in1_ratio;
	wire       in1_high;
	wire       in1_low;
	wire       in2_ratio;
	wire       in2_high;
	wire       in2_low;
	wire [6:0] own_addr = {`ADCSR_I2C_BASE_ADDR, addr_s};
	wire       wr_commit;
	wire [15:0] wr_word = {msb_hold_reg, shift_reg};

	assign sda_out = 1'b0;

	// pins pass inverted so the synchroniser's reset level is the idle-high bus
	adcsr_sync #(.WIDTH(2)) u_pin_sync (
		.clk      (clk),
		.reset_n  (reset_n),
		.async_in ({~sda_in, ~scl_in}),
		.sync_out (pins_n_s)
	);

	adcsr_sync #(.WIDTH(2)) u_addr_sync (
		.clk      (clk),
		.reset_n  (reset_n),
		.async_in (i2c_addr_sel),
		.sync_out (addr_s)
	);

	adcsr_sync #(.WIDTH(4)) u_serial_sync (
		.clk      (clk),
		.reset_n  (reset_n),
		.async_in ({serial2_frame_clock, serial2_bit_clock,
		            serial1_frame_clock, serial1_bit_clock}),
		.sync_out (serial_s)
	);

	adcsr_clkmon u_mon1 (
		.clk           (clk),
		.reset_n       (reset_n),
		.bit_clock_s   (serial_s[0]),
		.frame_clock_s (serial_s[1]),
		.period_min    (input1_period_min),
		.period_max    (input1_period_max),
		.ratio_expect  (input1_ratio_expect),
		.ratio_error   (in1_ratio),
		.rate_high     (in1_high),
		.rate_low      (in1_low)
	);

	adcsr_clkmon u_mon2 (
		.clk           (clk),
		.reset_n       (reset_n),
		.bit_clock_s   (serial_s[2]),
		.frame_clock_s (serial_s[3]),
		.period_min    (input2_period_min),
		.period_max    (input2_period_max),
		.ratio_expect  (input2_ratio_expect),
		.ratio_error   (in2_ratio),
		.rate_high     (in2_high),
		.rate_low      (in2_low)
	);

	// status word, rebuilt every cycle from live inputs
	always @* begin
		status_word = 16'h0000;
		status_word[`ADCSR_ST_SWITCHING_BIT] = power_stage_switching;
		status_word[`ADCSR_ST_REG_GOOD_BIT] = analog_regulator_on &
		                                      analog_regulator_level_ok;
		status_word[`ADCSR_ST_AMP_MSB:`ADCSR_ST_AMP_LSB] = output_stage_mode_state;
		status_word[`ADCSR_ST_IN2_RATIO_BIT] = in2_ratio;
		status_word[`ADCSR_ST_IN2_HIGH_BIT] = in2_high;
		status_word[`ADCSR_ST_IN2_LOW_BIT] = in2_low;
		status_word[`ADCSR_ST_IN1_RATIO_BIT] = in1_ratio;
		status_word[`ADCSR_ST_IN1_HIGH_BIT] = in1_high;
		status_word[`ADCSR_ST_IN1_LOW_BIT] = in1_low;
		status_word[`ADCSR_ST_OCP_A_BIT] = ~overcurrent_active_pin_a;
		status_word[`ADCSR_ST_OCP_B_BIT] = ~overcurrent_active_pin_b;
	end

	// read mux; unmapped pointers read zero
	always @* begin
		if (ptr_reg == `ADCSR_HP_FILTER_CTRL_OFS)
			rd_word = {7'h00, highpass_corner_setting};
		else if (ptr_reg == `ADCSR_GAIN_CTRL_OFS)
			rd_word = {3'h0, zero_cross_update_enable, gain_rsvd_reg, gain_setting};
		else if (ptr_reg == `ADCSR_MUTE_LIMITER_CTRL_OFS)
			rd_word = {4'h0, deemph_select, hard_mute_active, soft_mute_enable,
			           power_limit_setting};
		else if (ptr_reg == `ADCSR_MISC_STATUS_OFS)
			rd_word = status_word;
		else
			rd_word = 16'h0000;
	end

	assign wr_commit = (state_reg == ST_RX) && scl_fall && (bit_cnt_reg == 4'd8) &&
	                   !rw_reg && (byte_idx_reg == 2'd2) && half_reg;

	// I2C slave: address, pointer, then 16-bit words MSB first
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_d_reg    <= 1'b1;
			sda_d_reg    <= 1'b1;
			state_reg    <= ST_IDLE;
			bit_cnt_reg  <= 4'h0;
			shift_reg    <= 8'h00;
			byte_idx_reg <= 2'd0;
			rw_reg       <= 1'b0;
			half_reg     <= 1'b0;
			ptr_reg      <= 8'h00;
			msb_hold_reg <= 8'h00;
			mack_reg     <= 1'b1;
			sda_oe       <= 1'b0;
		end else begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
			if (start_cond) begin
				state_reg    <= ST_RX;
				bit_cnt_reg  <= 4'h0;
				byte_idx_reg <= 2'd0;
				half_reg     <= 1'b0;
				sda_oe       <= 1'b0;
			end else if (stop_cond) begin
				state_reg <= ST_IDLE;
				sda_oe    <= 1'b0;
			end else begin
				case (state_reg)
				ST_RX: begin
					if (scl_rise) begin
						shift_reg   <= {shift_reg[6:0], sda_s};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end else if (scl_fall && bit_cnt_reg == 4'd8) begin
						bit_cnt_reg <= 4'h0;
						if (byte_idx_reg == 2'd0) begin
							if (shift_reg[7:1] == own_addr) begin
								rw_reg       <= shift_reg[0];
								byte_idx_reg <= 2'd1;
								state_reg    <= ST_ACK;
								sda_oe       <= 1'b1;
							end else begin
								state_reg <= ST_IDLE;
							end
						end else begin
							if (byte_idx_reg == 2'd1) begin
								ptr_reg      <= shift_reg;
								byte_idx_reg <= 2'd2;
								half_reg     <= 1'b0;
							end else if (!half_reg) begin
								msb_hold_reg <= shift_reg;
								half_reg     <= 1'b1;
							end else begin
								ptr_reg  <= ptr_reg + 8'h01;
								half_reg <= 1'b0;
							end
							state_reg <= ST_ACK;
							sda_oe    <= 1'b1;
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						if (rw_reg) begin
							state_reg   <= ST_TX;
							shift_reg   <= half_reg ? rd_word[7:0] : rd_word[15:8];
							sda_oe      <= half_reg ? ~rd_word[7] : ~rd_word[15];
							bit_cnt_reg <= 4'h0;
						end else begin
							state_reg <= ST_RX;
							sda_oe    <= 1'b0;
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (bit_cnt_reg == 4'd7) begin
							state_reg <= ST_RACK;
							sda_oe    <= 1'b0;
							if (half_reg)
								ptr_reg <= ptr_reg + 8'h01;
							half_reg <= ~half_reg;
						end else begin
							shift_reg   <= {shift_reg[6:0], 1'b0};
							sda_oe      <= ~shift_reg[6];
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end
					end
				end
				ST_RACK: begin
					if (scl_rise)
						mack_reg <= sda_s;
					else if (scl_fall) begin
						if (!mack_reg) begin
							state_reg   <= ST_TX;
							shift_reg   <= half_reg ? rd_word[7:0] : rd_word[15:8];
							sda_oe      <= half_reg ? ~rd_word[7] : ~rd_word[15];
							bit_cnt_reg <= 4'h0;
						end else begin
							state_reg <= ST_IDLE;
						end
					end
				end
				default: begin
					state_reg <= ST_IDLE;
					sda_oe    <= 1'b0;
				end
				endcase
			end
		end
	end

	// control registers; status offset has no write path
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			highpass_corner_setting  <= `ADCSR_HP_CORNER_RST;
			gain_setting             <= `ADCSR_GAIN_RST;
			zero_cross_update_enable <= `ADCSR_ZERO_CROSS_RST;
			gain_rsvd_reg            <= `ADCSR_GAIN_RSVD_RST;
			deemph_select            <= `ADCSR_DEEMPH_RST;
			hard_mute_active         <= `ADCSR_HARD_MUTE_RST;
			soft_mute_enable         <= `ADCSR_SOFT_MUTE_RST;
			power_limit_setting      <= `ADCSR_PLIM_RST;
		end else if (wr_commit) begin
			if (ptr_reg == `ADCSR_HP_FILTER_CTRL_OFS) begin
				highpass_corner_setting <= wr_word[8:0];
			end else if (ptr_reg == `ADCSR_GAIN_CTRL_OFS) begin
				gain_setting             <= wr_word[7:0];
				gain_rsvd_reg            <= wr_word[11:8];
				zero_cross_update_enable <= wr_word[`ADCSR_ZERO_CROSS_BIT];
			end else if (ptr_reg == `ADCSR_MUTE_LIMITER_CTRL_OFS) begin
				deemph_select       <= wr_word[`ADCSR_DEEMPH_MSB:`ADCSR_DEEMPH_LSB];
				hard_mute_active    <= wr_word[`ADCSR_HARD_MUTE_BIT];
				soft_mute_enable    <= wr_word[`ADCSR_SOFT_MUTE_BIT];
				power_limit_setting <= wr_word[7:0];
			end
		end
	end

	// raised cosine ramp table, 17 points from silence to full
	function [7:0] adcsr_rcos;
		input [4:0] pos;
		begin
			case (pos)
			5'd0:    adcsr_rcos = 8'h00;
			5'd1:    adcsr_rcos = 8'h02;
			5'd2:    adcsr_rcos = 8'h09;
			5'd3:    adcsr_rcos = 8'h15;
			5'd4:    adcsr_rcos = 8'h25;
			5'd5:    adcsr_rcos = 8'h38;
			5'd6:    adcsr_rcos = 8'h4e;
			5'd7:    adcsr_rcos = 8'h66;
			5'd8:    adcsr_rcos = 8'h80;
			5'd9:    adcsr_rcos = 8'h99;
			5'd10:   adcsr_rcos = 8'hb1;
			5'd11:   adcsr_rcos = 8'hc7;
			5'd12:   adcsr_rcos = 8'hda;
			5'd13:   adcsr_rcos = 8'hea;
			5'd14:   adcsr_rcos = 8'hf6;
			5'd15:   adcsr_rcos = 8'hfd;
			default: adcsr_rcos = 8'hff;
			endcase
		end
	endfunction

	// gain apply, hard mute PWM and soft mute ramp
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			gain_applied     <= `ADCSR_GAIN_RST;
			pwm_cnt_reg      <= 16'h0000;
			mute_pwm         <= 1'b0;
			ramp_cnt_reg     <= 16'h0000;
			ramp_pos_reg     <= 5'd16;
			soft_mute_gain   <= 8'hff;
		end else begin
			// with zero-cross update on, a new gain waits for a crossing
			if (!zero_cross_update_enable || audio_zero_cross)
				gain_applied <= gain_setting;
			if (!hard_mute_active) begin
				pwm_cnt_reg <= 16'h0000;
				mute_pwm    <= 1'b0;
			end else if (pwm_cnt_reg == MUTE_PWM_HALF - 16'd1) begin
				pwm_cnt_reg <= 16'h0000;
				mute_pwm    <= ~mute_pwm;
			end else begin
				pwm_cnt_reg <= pwm_cnt_reg + 16'h0001;
			end
			if (ramp_cnt_reg == RAMP_STEP - 16'd1) begin
				ramp_cnt_reg <= 16'h0000;
				if (soft_mute_enable && ramp_pos_reg != 5'd0)
					ramp_pos_reg <= ramp_pos_reg - 5'd1;
				else if (!soft_mute_enable && ramp_pos_reg != 5'd16)
					ramp_pos_reg <= ramp_pos_reg + 5'd1;
			end else begin
				ramp_cnt_reg <= ramp_cnt_reg + 16'h0001;
			end
			soft_mute_gain <= adcsr_rcos(ramp_pos_reg);
		end
	end
endmodule // adcsr_top

// file: tb/adcsr_top_sva.sv
// checker for the amplifier control register group outputs
// assumes binding onto adcsr_top, one clock domain
module adcsr_top_sva #(
	parameter int MUTE_PWM_HALF = 2,
	parameter int RAMP_STEP     = 4
) (
	input logic       clk,
	input logic       reset_n,
	input logic       scl_in,
	input logic       audio_zero_cross,
	input logic [8:0] highpass_corner_setting,
	input logic [7:0] gain_setting,
	input logic [7:0] gain_applied,
	input logic [1:0] deemph_select,
	input logic [7:0] power_limit_setting,
	input logic       hard_mute_active,
	input logic       mute_pwm,
	input logic [7:0] soft_mute_gain
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PH1 = MUTE_PWM_HALF - 1;
	int         since_step;
	logic [7:0] prev_soft;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// cycles since the soft mute gain last moved
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			since_step <= RAMP_STEP;
			prev_soft  <= 8'hff;
		end else begin
			prev_soft <= soft_mute_gain;
			if (soft_mute_gain != prev_soft)
				since_step <= 0;
			else if (since_step < RAMP_STEP)
				since_step <= since_step + 1;
		end
	end
	a_reset_values: assert property ($rose(reset_n) |->
		highpass_corner_setting == 9'h004 && gain_setting == 8'hbd &&
		deemph_select == 2'h0 && power_limit_setting == 8'hbd)
		else $error("control outputs not at reset values");
	a_reset_mute_full: assert property ($rose(reset_n) |->
		soft_mute_gain == 8'hff && !hard_mute_active && !mute_pwm && gain_applied == 8'hbd)
		else $error("mute or applied gain not at reset values");
	a_applied_from_setting: assert property ($changed(gain_applied) |->
		gain_applied == $past(gain_setting))
		else $error("applied gain took a value other than the setting");
	a_zero_cross_take: assert property (
		audio_zero_cross && gain_applied != gain_setting |=> gain_applied == $past(gain_setting))
		else $error("gain not applied after zero crossing");
	a_pwm_high_len: assert property (hard_mute_active && $rose(mute_pwm) |->
		##PH1 (mute_pwm || !hard_mute_active) ##1 (!mute_pwm || !hard_mute_active))
		else $error("mute pwm high phase not half the period");
	a_pwm_idle_low: assert property (
		!hard_mute_active && !$past(hard_mute_active) |-> !mute_pwm)
		else $error("mute pwm toggling without hard mute");
	a_soft_step_rate: assert property (
		soft_mute_gain != prev_soft |-> since_step >= RAMP_STEP - 1)
		else $error("soft mute ramp stepped too fast");
	a_ctrl_scl_low: assert property ($changed({highpass_corner_setting,
		gain_setting, deemph_select, power_limit_setting}) |-> !scl_in)
		else $error("setting changed outside a write commit");
	c_hard_mute: cover property (hard_mute_active && $rose(mute_pwm));
	c_zero_cross: cover property (audio_zero_cross && gain_applied != gain_setting);
	c_soft_silent: cover property (soft_mute_gain == 8'h00);
endmodule // adcsr_top_sva

bind adcsr_top adcsr_top_sva #(.MUTE_PWM_HALF(MUTE_PWM_HALF), .RAMP_STEP(RAMP_STEP))
	adcsr_top_sva_i (
	.clk, .reset_n, .scl_in, .audio_zero_cross, .highpass_corner_setting, .gain_setting,
	.gain_applied, .deemph_select, .power_limit_setting, .hard_mute_active, .mute_pwm,
	.soft_mute_gain);

// file: tb/adcsr_top_tb.sv
// self-checking bench for the amplifier control register group
// assumes an I2C master here and an open-drain SDA line with pull-up
module adcsr_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
`include "adcsr_regs.vh"
	logic clk = 0, reset_n = 0, scl_in = 1, sda_m = 1, audio_zero_cross = 0;
	logic power_stage_switching = 0, analog_regulator_on = 0, analog_regulator_level_ok = 0;
	logic overcurrent_active_pin_a = 0, overcurrent_active_pin_b = 0;
	logic serial1_bit_clock = 0, serial1_frame_clock = 0;
	logic serial2_bit_clock = 0, serial2_frame_clock = 0;
	logic [1:0]  i2c_addr_sel = 2'h1, output_stage_mode_state = 2'h0, m;
	logic [15:0] input1_period_min = 16'h0038, input1_period_max = 16'h0048;
	logic [15:0] input2_period_min = 16'h0038, input2_period_max = 16'h0048;
	logic [7:0]  input1_ratio_expect = 8'h10, input2_ratio_expect = 8'h10, rb;
	logic [15:0] rd, ex;
	logic        ack;
	wire         sda_out, sda_oe, hard_mute_active, mute_pwm;
	wire  [8:0]  highpass_corner_setting;
	wire  [7:0]  gain_setting, gain_applied, power_limit_setting, soft_mute_gain;
	wire  [1:0]  deemph_select;
	wire         sda_in = sda_m & (sda_out | ~sda_oe);
	int          errors = 0, samples_checked = 0, nb1 = 16, nb2 = 16, hi;
	// ptr, write data, read back
	logic [39:0] rows [6] = '{{8'h12, 16'hffff, 16'h01ff}, {8'h13, 16'hffff, 16'h1fff},
		{8'h13, 16'h0055, 16'h0055}, {8'h14, 16'hffff, 16'h0fff},
		{8'h14, 16'h0000, 16'h0000}, {8'h20, 16'h1234, 16'h0000}};

	adcsr_top #(.MUTE_PWM_HALF(16'h0002), .RAMP_STEP(16'h0004)) adcsr_top_i (
		.clk, .reset_n, .scl_in, .sda_in, .sda_out, .sda_oe, .i2c_addr_sel,
		.serial1_bit_clock, .serial1_frame_clock, .serial2_bit_clock, .serial2_frame_clock,
		.input1_period_min, .input1_period_max, .input1_ratio_expect,
		.input2_period_min, .input2_period_max, .input2_ratio_expect,
		.audio_zero_cross, .power_stage_switching, .analog_regulator_on,
		.analog_regulator_level_ok, .output_stage_mode_state, .overcurrent_active_pin_a,
		.overcurrent_active_pin_b, .highpass_corner_setting, .gain_setting, .gain_applied,
		.deemph_select, .power_limit_setting, .hard_mute_active, .mute_pwm,
		.soft_mute_gain);

	initial forever #10 clk = ~clk;

	task automatic hp(int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic chk(logic [15:0] seen, logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// one byte plus the ninth bit, sampled mid high phase
	task automatic xfer(logic [7:0] tx, logic ab, output logic [7:0] rx, output logic ar);
		for (int i = 0; i < 9; i++) begin
			sda_m = (i < 8) ? tx[7-i] : ab;
			hp(8);
			scl_in = 1;
			hp(2);
			if (i < 8)
				rx[7-i] = sda_in;
			else
				ar = sda_in;
			hp(3);
			scl_in = 0;
		end
	endtask
	task automatic start;
		sda_m = 1;
		hp(8);
		scl_in = 1;
		hp(5);
		sda_m = 0;
		hp(5);
		scl_in = 0;
	endtask
	task automatic stop;
		sda_m = 0;
		hp(8);
		scl_in = 1;
		hp(5);
		sda_m = 1;
		hp(5);
	endtask
	task automatic wr(logic [7:0] p, logic [15:0] d);
		start();
		xfer({`ADCSR_I2C_BASE_ADDR, 2'h1, 1'b0}, 1'b1, rb, ack);
		xfer(p, 1'b1, rb, ack);
		xfer(d[15:8], 1'b1, rb, ack);
		xfer(d[7:0], 1'b1, rb, ack);
		stop();
	endtask
	task automatic rdw(logic [7:0] p, output logic [15:0] d);
		start();
		xfer({`ADCSR_I2C_BASE_ADDR, 2'h1, 1'b0}, 1'b1, rb, ack);
		xfer(p, 1'b1, rb, ack);
		start();
		xfer({`ADCSR_I2C_BASE_ADDR, 2'h1, 1'b1}, 1'b1, rb, ack);
		xfer(8'hff, 1'b0, d[15:8], ack);
		xfer(8'hff, 1'b1, d[7:0], ack);
		stop();
	endtask
	// frame of nb bit clocks, four clk cycles each
	task automatic gen(ref logic bc, ref logic fc, ref int nb);
		forever begin
			for (int i = 0; i < nb; i++) begin
				fc = (i < nb / 2);
				bc = 0;
				hp(2);
				bc = 1;
				hp(2);
			end
		end
	endtask
	task automatic mon_chk(logic [15:0] exp);
		hp(400);
		rdw(`ADCSR_MISC_STATUS_OFS, rd);
		chk(rd & 16'h01f8, exp);
	endtask

	initial fork
		gen(serial1_bit_clock, serial1_frame_clock, nb1);
		gen(serial2_bit_clock, serial2_frame_clock, nb2);
	join

	initial begin
		repeat (40000) @(posedge clk);
		errors++;
		print_verdict();
	end

	initial begin
		hp(10);
		reset_n = 1;
		hp(5);
		foreach (rows[k]) begin
			wr(rows[k][39:32], rows[k][31:16]);
			rdw(rows[k][39:32], rd);
			chk(rd, rows[k][15:0]);
		end
		chk({7'h00, highpass_corner_setting}, 16'h01ff);
		wr(`ADCSR_MUTE_LIMITER_CTRL_OFS, 16'h0c5a);
		chk({deemph_select, 6'h00, power_limit_setting}, 16'hc05a);
		$display("test table done");
		chk({8'h00, gain_applied}, 16'h0055);
		wr(`ADCSR_GAIN_CTRL_OFS, 16'h1077);
		hp(20);
		chk({gain_setting, gain_applied}, 16'h7755);
		audio_zero_cross = 1;
		hp(1);
		audio_zero_cross = 0;
		hp(3);
		chk({8'h00, gain_applied}, 16'h0077);
		$display("test zero cross done");
		wr(`ADCSR_MUTE_LIMITER_CTRL_OFS, 16'h0200);
		hp(10);
		hi = 0;
		for (int i = 0; i < 40; i++) begin
			hp(1);
			hi += mute_pwm;
		end
		chk({hi[14:0], hard_mute_active}, 16'h0029);
		wr(`ADCSR_MUTE_LIMITER_CTRL_OFS, 16'h0100);
		hp(150);
		chk({soft_mute_gain, 7'h00, hard_mute_active}, 16'h0000);
		wr(`ADCSR_MUTE_LIMITER_CTRL_OFS, 16'h0000);
		hp(150);
		chk({8'h00, soft_mute_gain}, 16'h00ff);
		$display("test mute done");
		for (int j = 0; j < 4; j++) begin
			m = j[1:0];
			output_stage_mode_state = m;
			power_stage_switching = m[0];
			analog_regulator_on = ~m[0];
			analog_regulator_level_ok = m[1];
			overcurrent_active_pin_a = m[0];
			overcurrent_active_pin_b = ~m[0];
			wr(`ADCSR_MISC_STATUS_OFS, 16'hffff);
			rdw(`ADCSR_MISC_STATUS_OFS, rd);
			ex = {1'b0, m[0], ~m[0] & m[1], 2'h0, m, 6'h00, ~m[0], m[0], 1'b0};
			chk(rd, ex);
		end
		$display("test status done");
		start();
		xfer({`ADCSR_I2C_BASE_ADDR, 2'h2, 1'b0}, 1'b1, rb, ack);
		stop();
		chk({15'h0000, ack}, 16'h0001);
		$display("test address done");
		nb1 = 12;
		nb2 = 20;
		mon_chk(16'h0170);
		input1_period_min = 16'h0028;
		input1_period_max = 16'h0034;
		input1_ratio_expect = 8'h0c;
		input2_period_min = 16'h004c;
		input2_period_max = 16'h0058;
		input2_ratio_expect = 8'h14;
		mon_chk(16'h0000);
		nb1 = 20;
		nb2 = 12;
		mon_chk(16'h01a8);
		$display("test clock monitor done");
		reset_n = 0;
		hp(3);
		reset_n = 1;
		hp(5);
		chk({7'h00, highpass_corner_setting}, 16'h0004);
		chk({gain_setting, gain_applied}, 16'hbdbd);
		chk({soft_mute_gain, power_limit_setting}, 16'hffbd);
		chk({13'h0000, deemph_select, hard_mute_active}, 16'h0000);
		for (int j = 0; j < 3; j++) begin
			rdw(8'h12 + j[7:0], rd);
			ex = (j == 0) ? 16'h0004 : (j == 1) ? 16'h10bd : 16'h00bd;
			chk(rd, ex);
		end
		$display("test reset done");
		print_verdict();
	end
endmodule // adcsr_top_tb
